//--- bench/bdm_host_model.sv
// development host model: shifts words in and answers out on the debug link
`timescale 1ns/1ns
module bdm_host_model (
  // clock
  input wire logic clk,
  // link pins
  output logic     dbgClk,
  output logic     dbgIn,
  input wire logic dbgOut
);
  ////////////////////////////////////////////////////////////////////////////////
  // link clock stands low between frames
  initial begin
    dbgClk = 1'b0;
    dbgIn = 1'b0;
  end
  // one 32-bit word each way, msb first, 8 system clocks per link bit
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    @(negedge clk);
    for (int i = 31; i >= 0; i--) begin
      dbgIn = w[i];
      repeat (4) @(negedge clk);
      r[i] = dbgOut;
      dbgClk = 1'b1;
      repeat (4) @(negedge clk);
      dbgClk = 1'b0;
    end
    dbgIn = ~w[0]; // idle line shows no stale bit
    repeat (24) @(negedge clk); // gap lets the answer be posted
  endtask : xfer
endmodule : bdm_host_model

//--- bench/bdm_unit_props.sv
// concurrent checks on the ports of the background debug command unit
`timescale 1ns/1ns
module bdm_unit_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // core status
  input wire logic        inBackground,
  input wire logic [31:0] progCounter,
  input wire logic [31:0] stackPtr,
  input wire logic [2:0]  srcSpace,
  input wire logic [2:0]  dstSpace,
  // core register port
  input wire logic        regReq,
  input wire logic        regWr,
  input wire logic [1:0]  regClass,
  input wire logic [3:0]  regIdx,
  input wire logic        regAck,
  // memory port
  input wire logic        memReq,
  input wire logic        memWr,
  input wire logic [31:0] memAddr,
  input wire logic [2:0]  memSpace,
  input wire logic [31:0] memWdata,
  input wire logic        memAck,
  // execution control
  input wire logic        resumePulse,
  input wire logic        patchCallPulse,
  input wire logic        periphReset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [10:0] resetRun;
  ////////////////////////////////////////////////////////////////////////////////
  // length of the current peripheral reset run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) resetRun <= 11'h000;
    else if (periphReset) resetRun <= resetRun + 11'h001;
    else resetRun <= 11'h000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // a request waits with its qualifiers frozen, then is dropped after the answer
  sequence regWaiting;
    regReq && !regAck;
  endsequence
  sequence memWaiting;
    memReq && !memAck;
  endsequence
  property regHeld;
    regWaiting |=> regReq && $stable(regWr) && $stable(regClass) && $stable(regIdx);
  endproperty
  property memHeld;
    memWaiting |=> memReq && $stable(memWr) && $stable(memAddr) && $stable(memSpace);
  endproperty
  reg_hold_a: assert property (regHeld) else $error("register request not held");
  reg_release_a: assert property (regAck |=> !regReq) else $error("register request kept");
  mem_hold_a: assert property (memHeld) else $error("memory request not held");
  mem_release_a: assert property (memAck |=> !memReq) else $error("memory request kept");
  read_space_a: assert property (memReq && !memWr |-> memSpace == srcSpace)
    else $error("read in wrong space");
  write_space_a: assert property (memReq && memWr |-> memSpace == dstSpace ||
    (memSpace == bdm_pkg::SPACE_SUPV_DATA && memAddr == stackPtr - bdm_pkg::STACK_STEP && memWdata == progCounter))
    else $error("write in wrong space");
  resume_pulse_a: assert property (resumePulse |=> !resumePulse) else $error("resume pulse too long");
  patch_after_ack_a: assert property (patchCallPulse |-> $past(memAck) && $past(memWr))
    else $error("patch call without stacked counter");
  reset_length_a: assert property ($fell(periphReset) |-> resetRun == 11'h200)
    else $error("peripheral reset length wrong");
  reset_bound_a: assert property (periphReset |-> resetRun < 11'h200) else $error("reset overlong");
  background_only_a: assert property ($rose(regReq) |-> inBackground)
    else $error("command run outside background");
endmodule : bdm_unit_props

bind bdm_unit bdm_unit_props i_bdm_unit_props (.clk(clk), .rst(rst), .inBackground(inBackground),
  .progCounter(progCounter), .stackPtr(stackPtr), .srcSpace(srcSpace), .dstSpace(dstSpace),
  .regReq(regReq), .regWr(regWr), .regClass(regClass), .regIdx(regIdx), .regAck(regAck),
  .memReq(memReq), .memWr(memWr), .memAddr(memAddr), .memSpace(memSpace), .memWdata(memWdata),
  .memAck(memAck), .resumePulse(resumePulse), .patchCallPulse(patchCallPulse), .periphReset(periphReset));

//--- bench/tb_bdm_unit.sv
// self-checking bench for the background debug command unit
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_bdm_unit;
  logic        clk, rst, dbgClk, dbgIn, dbgOut, inBackground, regReq, regWr, regAck, memReq, memWr, memAck;
  logic        resumePulse, patchCallPulse, periphReset;
  logic [31:0] progCounter, stackPtr, regWdata, regRdata, memAddr, memWdata, memRdata, rsp, a, d, lastAddr;
  logic [2:0]  srcSpace, dstSpace, memSpace, lastSpace;
  logic [1:0]  regClass, memSize, lastSize;
  logic [3:0]  regIdx, idx;
  logic [31:0] regs [64];
  logic [31:0] mem [logic [31:0]];
  logic [3:0]  wrOps [3] = '{bdm_pkg::CMD_WR_DREG, bdm_pkg::CMD_WR_AREG, bdm_pkg::CMD_WR_SYS};
  logic [3:0]  rdOps [3] = '{bdm_pkg::CMD_RD_DREG, bdm_pkg::CMD_RD_AREG, bdm_pkg::CMD_RD_SYS};
  int          errors, checks, pulses, rstLen, acks;
  bdm_unit i_bdm_unit (.clk(clk), .rst(rst), .dbgClk(dbgClk), .dbgIn(dbgIn), .dbgOut(dbgOut),
    .inBackground(inBackground), .progCounter(progCounter), .stackPtr(stackPtr), .srcSpace(srcSpace),
    .dstSpace(dstSpace), .regReq(regReq), .regWr(regWr), .regClass(regClass), .regIdx(regIdx),
    .regWdata(regWdata), .regAck(regAck), .regRdata(regRdata), .memReq(memReq), .memWr(memWr),
    .memAddr(memAddr), .memSize(memSize), .memSpace(memSpace), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .resumePulse(resumePulse), .patchCallPulse(patchCallPulse), .periphReset(periphReset));
  bdm_host_model i_bdm_host_model (.clk(clk), .dbgClk(dbgClk), .dbgIn(dbgIn), .dbgOut(dbgOut));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1200000;
    errors++;
    summarize();
  end
  // core and memory answer after a random wait, counting pulses and reset cycles
  always @(negedge clk) begin
    regAck = 1'b0;
    memAck = 1'b0;
    if (regReq && $urandom_range(1)) begin
      if (regWr) regs[{regClass, regIdx}] = regWdata;
      regRdata = regs[{regClass, regIdx}];
      regAck = 1'b1;
      acks++;
    end
    if (memReq && $urandom_range(1)) begin
      lastAddr = memAddr;
      lastSpace = memSpace;
      lastSize = memSize;
      if (memWr) mem[memAddr] = memWdata;
      memRdata = mem.exists(memAddr) ? mem[memAddr] : ~memAddr;
      memAck = 1'b1;
      acks++;
    end
    if (resumePulse || patchCallPulse) pulses++;
    if (periphReset) rstLen++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic x(input logic [31:0] w);
    i_bdm_host_model.xfer(w, rsp);
  endtask : x
  function automatic logic [31:0] step(input logic [1:0] s);
    return s == bdm_pkg::SIZE_BYTE ? 32'h1 : s == bdm_pkg::SIZE_WORD ? 32'h2 : 32'h4;
  endfunction : step
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    void'($urandom(32'hf35a));
    {rst, inBackground, regAck, memAck, regRdata, memRdata} = {1'b1, 1'b1, 66'h0};
    {progCounter, stackPtr, srcSpace, dstSpace} = {$urandom, $urandom & 32'hffff_fffc, 3'h1, 3'h2};
    for (int i = 0; i < 64; i++) regs[i] = $urandom;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int c = 0; c < 9; c++) begin
      {idx, d} = {4'($urandom), $urandom};
      x({wrOps[c % 3], 24'h0, idx});
      x(d);
      x({rdOps[c % 3], 24'h0, idx});
      x(32'h0); // answer is taken at the end of this word
      x(32'h0); // and shifted out in this one
      `CHK(rsp, d)
      `CHK(regs[{2'(c % 3), idx}], d)
    end
    $display("register access test done");
    for (int s = 0; s < 3; s++) begin
      {a, d} = {$urandom & 32'hffff_fff0, $urandom};
      x({bdm_pkg::CMD_WRITE, 2'(s), 26'h0});
      x(a);
      x(d);
      x({bdm_pkg::CMD_FILL, 28'h0});
      x(d + 32'h1);
      x(32'h0);
      `CHK(mem[a], d)
      `CHK(lastSpace, dstSpace)
      `CHK(lastAddr, a + step(2'(s)))
      `CHK(mem[a + step(2'(s))], d + 32'h1)
      x({bdm_pkg::CMD_READ, 2'(s), 26'h0});
      x(a);
      x(32'h0);
      x(32'h0);
      `CHK(lastSize, 2'(s))
      `CHK(rsp, d)
      `CHK(lastSpace, srcSpace)
      x({bdm_pkg::CMD_DUMP, 28'h0});
      x(32'h0);
      x(32'h0);
      `CHK(lastSize, 2'(s))
      `CHK(rsp, d + 32'h1)
      `CHK(lastAddr, a + step(2'(s)))
    end
    $display("memory block test done");
    acks = 0;
    x(32'h0);
    x(32'he000_0000);
    inBackground = 1'b0;
    x({bdm_pkg::CMD_WR_DREG, 28'h1});
    x($urandom);
    inBackground = 1'b1;
    x(32'h0);
    `CHK(acks, 0)
    $display("null and halted test done");
    pulses = 0;
    x({bdm_pkg::CMD_GO, 28'h0});
    x(32'h0);
    `CHK(pulses, 1)
    x({bdm_pkg::CMD_CALL, 28'h0});
    x(32'h0);
    `CHK(pulses, 2)
    `CHK(mem[stackPtr - bdm_pkg::STACK_STEP], progCounter)
    `CHK(lastSpace, bdm_pkg::SPACE_SUPV_DATA)
    `CHK(lastSize, bdm_pkg::SIZE_LONG)
    rstLen = 0;
    x({bdm_pkg::CMD_RST, 28'h0});
    repeat (600) @(negedge clk);
    `CHK(rstLen, bdm_pkg::RST_CYCLES)
    $display("execution control test done");
    summarize();
  end
endmodule : tb_bdm_unit

//--- hw/bdm_link.sv
// serial word shifter for the debug link, sampled on the system clock
`timescale 1ns/1ns
module bdm_link #(
  parameter int W = bdm_pkg::WORD_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // link pins
  input  wire logic         dbgClk,
  input  wire logic         dbgIn,
  output logic              dbgOut,
  // word side
  output logic [W-1:0]      rxWord,
  output logic              rxValid,
  input  wire logic [W-1:0] txWord
);

  logic [1:0]          pinSync;
  logic                clkPrev;
  logic                rise;
  logic                fall;
  logic [W-1:0]        rxShift;
  logic [W-1:0]        txShift;
  logic [$clog2(W)-1:0] bitCnt;

  bdm_sync #(.W(2)) pinSyncInst (
    .clk    (clk),
    .rst    (rst),
    .async  ({dbgClk, dbgIn}),
    .synced (pinSync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // edge finder on the synchronised debug clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkPrev <= 1'b0;
    end else begin
      clkPrev <= pinSync[1];
    end
  end

  assign rise = pinSync[1] & ~clkPrev;
  assign fall = ~pinSync[1] & clkPrev;

  // receive: sample on rising edge, word done after W bits, msb first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxShift <= '0;
      rxWord  <= '0;
      rxValid <= 1'b0;
      bitCnt  <= '0;
    end else begin
      rxValid <= 1'b0;
      if (rise) begin
        rxShift <= {rxShift[W-2:0], pinSync[0]};
        if (bitCnt == ($clog2(W))'(W - 1)) begin
          rxWord  <= {rxShift[W-2:0], pinSync[0]};
          rxValid <= 1'b1;
          bitCnt  <= '0;
        end else begin
          bitCnt <= bitCnt + 1'b1;
        end
      end
    end
  end

  // transmit: answer loaded at word end, shifted out on falling edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txShift <= '0;
      dbgOut  <= 1'b0;
    end else if (rise && bitCnt == ($clog2(W))'(W - 1)) begin
      txShift <= txWord;
    end else if (fall) begin
      dbgOut  <= txShift[W-1];
      txShift <= {txShift[W-2:0], 1'b0};
    end
  end

endmodule : bdm_link

//--- hw/bdm_pkg.sv
// constants and command encodings for the background debug command unit
package bdm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // serial word and command word layout
  localparam int          WORD_W       = 32;
  localparam int          OP_MSB       = 31;
  localparam int          OP_LSB       = 28;
  localparam int          SIZE_MSB     = 27;
  localparam int          SIZE_LSB     = 26;
  localparam int          REG_MSB      = 3;
  localparam int          REG_LSB      = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // command opcodes
  localparam logic [3:0]  CMD_NOP      = 4'h0;
  localparam logic [3:0]  CMD_RD_DREG  = 4'h1;
  localparam logic [3:0]  CMD_RD_AREG  = 4'h2;
  localparam logic [3:0]  CMD_WR_DREG  = 4'h3;
  localparam logic [3:0]  CMD_WR_AREG  = 4'h4;
  localparam logic [3:0]  CMD_RD_SYS   = 4'h5;
  localparam logic [3:0]  CMD_WR_SYS   = 4'h6;
  localparam logic [3:0]  CMD_READ     = 4'h7;
  localparam logic [3:0]  CMD_WRITE    = 4'h8;
  localparam logic [3:0]  CMD_DUMP     = 4'h9;
  localparam logic [3:0]  CMD_FILL     = 4'ha;
  localparam logic [3:0]  CMD_GO       = 4'hb;
  localparam logic [3:0]  CMD_CALL     = 4'hc;
  localparam logic [3:0]  CMD_RST      = 4'hd;

  ////////////////////////////////////////////////////////////////////////////////
  // operand sizes, register classes, spaces, answers, reset values
  localparam logic [1:0]  SIZE_BYTE    = 2'h0;
  localparam logic [1:0]  SIZE_WORD    = 2'h1;
  localparam logic [1:0]  SIZE_LONG    = 2'h2;
  localparam logic [1:0]  CLASS_DATA   = 2'h0;
  localparam logic [1:0]  CLASS_ADDR   = 2'h1;
  localparam logic [1:0]  CLASS_SYS    = 2'h2;
  localparam logic [2:0]  SPACE_SUPV_DATA = 3'h5;
  localparam logic [31:0] STACK_STEP   = 32'h0000_0004;
  localparam logic [31:0] RESP_NONE    = 32'h0000_0000;
  localparam logic [31:0] RESP_BUSY    = 32'hffff_ffff;

  ////////////////////////////////////////////////////////////////////////////////
  // peripheral reset length in clock cycles
  localparam int          RST_CYCLES   = 512;
  localparam int          RST_CNT_W    = 10;
  localparam logic [9:0]  RST_LOAD     = 10'(RST_CYCLES - 1);

endpackage : bdm_pkg

//--- hw/bdm_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
module bdm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta   <= '0;
      synced <= '0;
    end else begin
      meta   <= async;
      synced <= meta;
    end
  end

endmodule : bdm_sync

//--- hw/bdm_unit.sv
// background debug command unit: decodes host words and drives core, memory and reset
`timescale 1ns/1ns
module bdm_unit (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // debug link pins
  input  wire logic        dbgClk,
  input  wire logic        dbgIn,
  output logic             dbgOut,
  // core status
  input  wire logic        inBackground,
  input  wire logic [31:0] progCounter,
  input  wire logic [31:0] stackPtr,
  input  wire logic [2:0]  srcSpace,
  input  wire logic [2:0]  dstSpace,
  // core register port
  output logic             regReq,
  output logic             regWr,
  output logic [1:0]       regClass,
  output logic [3:0]       regIdx,
  output logic [31:0]      regWdata,
  input  wire logic        regAck,
  input  wire logic [31:0] regRdata,
  // memory port
  output logic             memReq,
  output logic             memWr,
  output logic [31:0]      memAddr,
  output logic [1:0]       memSize,
  output logic [2:0]       memSpace,
  output logic [31:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  // execution control
  output logic             resumePulse,
  output logic             patchCallPulse,
  output logic             periphReset
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_REG,
    ST_MEM
  } bdm_state_t;

  bdm_state_t                  state;
  logic [31:0]                 rxWord;
  logic                        rxValid;
  logic [31:0]                 txWord;
  logic [3:0]                  opcode;
  logic [3:0]                  rxOp;
  logic                        blockValid;
  logic                        rstStart;
  logic [31:0]                 step;
  logic [bdm_pkg::RST_CNT_W-1:0] rstCnt;
  logic                        isRegRd;
  logic                        isRegWr;
  logic [1:0]                  cmdClass;
  logic                        cmdTaken;
  logic                        addrTaken;
  logic                        dataToMem;
  logic                        dataToReg;
  logic                        regDone;
  logic                        memDone;

  bdm_link #(.W(bdm_pkg::WORD_W)) linkInst (
    .clk     (clk),
    .rst     (rst),
    .dbgClk  (dbgClk),
    .dbgIn   (dbgIn),
    .dbgOut  (dbgOut),
    .rxWord  (rxWord),
    .rxValid (rxValid),
    .txWord  (txWord)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // command field and address step for the held operand size
  assign rxOp = rxWord[bdm_pkg::OP_MSB:bdm_pkg::OP_LSB];

  always_comb begin
    unique case (memSize)
      bdm_pkg::SIZE_BYTE: step = 32'h0000_0001;
      bdm_pkg::SIZE_WORD: step = 32'h0000_0002;
      default:            step = 32'h0000_0004;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the received word against the sequencer state
  always_comb begin
    isRegRd   = (rxOp == bdm_pkg::CMD_RD_DREG) || (rxOp == bdm_pkg::CMD_RD_AREG) || (rxOp == bdm_pkg::CMD_RD_SYS);
    isRegWr   = (rxOp == bdm_pkg::CMD_WR_DREG) || (rxOp == bdm_pkg::CMD_WR_AREG) || (rxOp == bdm_pkg::CMD_WR_SYS);
    cmdClass  = bdm_pkg::CLASS_SYS;
    if (rxOp == bdm_pkg::CMD_RD_DREG || rxOp == bdm_pkg::CMD_WR_DREG) begin
      cmdClass = bdm_pkg::CLASS_DATA;
    end else if (rxOp == bdm_pkg::CMD_RD_AREG || rxOp == bdm_pkg::CMD_WR_AREG) begin
      cmdClass = bdm_pkg::CLASS_ADDR;
    end
    // command words that arrive while the core runs are dropped here
    cmdTaken  = rxValid && inBackground && (state == ST_IDLE);
    addrTaken = rxValid && (state == ST_ADDR);
    dataToMem = rxValid && (state == ST_DATA) &&
                (opcode == bdm_pkg::CMD_WRITE || opcode == bdm_pkg::CMD_FILL);
    dataToReg = rxValid && (state == ST_DATA) && !dataToMem;
    regDone   = regAck && (state == ST_REG);
    memDone   = memAck && (state == ST_MEM);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command sequencer: which word is expected next and whether a block may go on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= ST_IDLE;
      opcode     <= bdm_pkg::CMD_NOP;
      blockValid <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmdTaken) begin
            opcode <= rxOp;
            unique case (rxOp)
              bdm_pkg::CMD_RD_DREG, bdm_pkg::CMD_RD_AREG, bdm_pkg::CMD_RD_SYS: begin
                state <= ST_REG;
              end
              bdm_pkg::CMD_WR_DREG, bdm_pkg::CMD_WR_AREG, bdm_pkg::CMD_WR_SYS: begin
                state <= ST_DATA;
              end
              bdm_pkg::CMD_READ, bdm_pkg::CMD_WRITE: begin
                state <= ST_ADDR;
              end
              bdm_pkg::CMD_DUMP: begin
                if (blockValid) begin
                  state <= ST_MEM;
                end
              end
              bdm_pkg::CMD_FILL: begin
                if (blockValid) begin
                  state <= ST_DATA;
                end
              end
              bdm_pkg::CMD_CALL: begin
                // the stacking write breaks any block in progress
                blockValid <= 1'b0;
                state      <= ST_MEM;
              end
              bdm_pkg::CMD_GO, bdm_pkg::CMD_RST: begin
                // strobes only, no operand follows
                state <= ST_IDLE;
              end
              default: begin
                // no operation and unknown codes leave state, opcode and blockValid alone
                opcode <= opcode;
              end
            endcase
          end
        end
        ST_ADDR: begin
          if (addrTaken) begin
            state <= (opcode == bdm_pkg::CMD_READ) ? ST_MEM : ST_DATA;
          end
        end
        ST_DATA: begin
          if (dataToMem) begin
            state <= ST_MEM;
          end else if (dataToReg) begin
            state <= ST_REG;
          end
        end
        ST_REG: begin
          if (regDone) begin
            state <= ST_IDLE;
          end
        end
        ST_MEM: begin
          if (memDone) begin
            if (opcode != bdm_pkg::CMD_CALL) begin
              blockValid <= 1'b1;
            end
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core register port: request stands with its qualifiers until the core answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regReq   <= 1'b0;
      regWr    <= 1'b0;
      regClass <= bdm_pkg::CLASS_DATA;
      regIdx   <= 4'h0;
      regWdata <= 32'h0000_0000;
    end else if (cmdTaken) begin
      regIdx <= rxWord[bdm_pkg::REG_MSB:bdm_pkg::REG_LSB];
      if (isRegRd || isRegWr) begin
        regClass <= cmdClass;
      end
      if (isRegRd) begin
        regReq <= 1'b1;
        regWr  <= 1'b0;
      end
    end else if (dataToReg) begin
      regWdata <= rxWord;
      regWr    <= 1'b1;
      regReq   <= 1'b1;
    end else if (regDone) begin
      regReq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // memory port: address, space and data set up with the request, held to the answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memReq   <= 1'b0;
      memWr    <= 1'b0;
      memAddr  <= 32'h0000_0000;
      memSize  <= bdm_pkg::SIZE_BYTE;
      memSpace <= 3'h0;
      memWdata <= 32'h0000_0000;
    end else if (cmdTaken) begin
      if (rxOp == bdm_pkg::CMD_READ || rxOp == bdm_pkg::CMD_WRITE) begin
        memSize <= rxWord[bdm_pkg::SIZE_MSB:bdm_pkg::SIZE_LSB];
      end
      if (rxOp == bdm_pkg::CMD_DUMP && blockValid) begin
        memAddr  <= memAddr + step;
        memWr    <= 1'b0;
        memSpace <= srcSpace;
        memReq   <= 1'b1;
      end
      if (rxOp == bdm_pkg::CMD_CALL) begin
        memAddr  <= stackPtr - bdm_pkg::STACK_STEP;
        memWdata <= progCounter;
        memSize  <= bdm_pkg::SIZE_LONG;
        memSpace <= bdm_pkg::SPACE_SUPV_DATA;
        memWr    <= 1'b1;
        memReq   <= 1'b1;
      end
    end else if (addrTaken) begin
      memAddr <= rxWord;
      if (opcode == bdm_pkg::CMD_READ) begin
        memWr    <= 1'b0;
        memSpace <= srcSpace;
        memReq   <= 1'b1;
      end
    end else if (dataToMem) begin
      if (opcode == bdm_pkg::CMD_FILL) begin
        memAddr <= memAddr + step;
      end
      memWdata <= rxWord;
      memWr    <= 1'b1;
      memSpace <= dstSpace;
      memReq   <= 1'b1;
    end else if (memDone) begin
      memReq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // answer word: busy while a read runs, then its data; a finished read beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txWord <= bdm_pkg::RESP_NONE;
    end else if (regDone && !regWr) begin
      txWord <= regRdata;
    end else if (memDone && !memWr) begin
      txWord <= memRdata;
    end else if (cmdTaken && (isRegRd || (rxOp == bdm_pkg::CMD_DUMP && blockValid))) begin
      txWord <= bdm_pkg::RESP_BUSY;
    end else if (addrTaken && opcode == bdm_pkg::CMD_READ) begin
      txWord <= bdm_pkg::RESP_BUSY;
    end else if (rxValid) begin
      // the shifter has just taken the answer, so it goes out once only
      txWord <= bdm_pkg::RESP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle execution control strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resumePulse    <= 1'b0;
      patchCallPulse <= 1'b0;
      rstStart       <= 1'b0;
    end else begin
      resumePulse    <= cmdTaken && (rxOp == bdm_pkg::CMD_GO);
      patchCallPulse <= memDone && (opcode == bdm_pkg::CMD_CALL);
      rstStart       <= cmdTaken && (rxOp == bdm_pkg::CMD_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // peripheral reset stretcher, core reset is never touched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rstCnt      <= '0;
      periphReset <= 1'b0;
    end else if (rstStart) begin
      rstCnt      <= bdm_pkg::RST_LOAD;
      periphReset <= 1'b1;
    end else if (periphReset) begin
      if (rstCnt == '0) begin
        periphReset <= 1'b0;
      end else begin
        rstCnt <= rstCnt - 1'b1;
      end
    end
  end

endmodule : bdm_unit
